// ### design/pmmcs_pkg.sv
// shared opcodes, element sizes and lane constants for the packed datapath
package pmmcs_pkg;

  // operation select
  typedef enum logic [3:0]
  {
    PMMCS_OP_PASS,
    PMMCS_OP_BYTE_REV,
    PMMCS_OP_MAX,
    PMMCS_OP_MIN,
    PMMCS_OP_ADD_WRAP,
    PMMCS_OP_SUB_WRAP,
    PMMCS_OP_ADD_SSAT,
    PMMCS_OP_SUB_SSAT,
    PMMCS_OP_ADD_USAT,
    PMMCS_OP_SUB_USAT,
    PMMCS_OP_CLIP
  } pmmcs_op_e;

  // element size select
  typedef enum logic [1:0]
  {
    PMMCS_SZ_BYTE,
    PMMCS_SZ_WORD,
    PMMCS_SZ_DWORD
  } pmmcs_size_e;

  localparam int unsigned DATA_W     = 128;
  localparam int unsigned NARROW_W   = 64;
  localparam int unsigned BYTE_LANES = 16;
  localparam int unsigned WORD_LANES = 8;
  localparam int unsigned DWORD_LANES = 4;
  // offset that maps signed words onto unsigned ordering
  localparam logic [15:0] WORD_SIGN_OFFSET = 16'h8000;
  localparam logic [15:0] WORD_USAT_MAX    = 16'hFFFF;

endpackage

// ### design/pmmcs_lane_cmp.sv
// one element lane: compare, wrap and saturate for byte, word or dword width
`timescale 1ns/1ps
module pmmcs_lane_cmp #(
  parameter int unsigned W = 8
) (
  // operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  input  wire logic         i_signed,
  // results
  output logic      [W-1:0] o_max,
  output logic      [W-1:0] o_min,
  output logic      [W-1:0] o_add_wrap,
  output logic      [W-1:0] o_sub_wrap,
  output logic      [W-1:0] o_add_ssat,
  output logic      [W-1:0] o_sub_ssat,
  output logic      [W-1:0] o_add_usat,
  output logic      [W-1:0] o_sub_usat
);

  logic         a_lt_b;
  logic [W:0]   usum;
  logic [W:0]   udif;
  logic [W-1:0] smax;
  logic [W-1:0] smin;

  // signed or unsigned ordering; widths stay within this lane only
  always_comb
  begin
    smax = {1'b0, {(W-1){1'b1}}};
    smin = {1'b1, {(W-1){1'b0}}};
    if (i_signed)
      a_lt_b = $signed(i_a) < $signed(i_b);
    else
      a_lt_b = i_a < i_b;
    o_max = a_lt_b ? i_b : i_a;
    o_min = a_lt_b ? i_a : i_b;
    usum = {1'b0, i_a} + {1'b0, i_b};
    udif = {1'b0, i_a} - {1'b0, i_b};
    o_add_wrap = usum[W-1:0];
    o_sub_wrap = udif[W-1:0];
    o_add_usat = usum[W] ? {W{1'b1}} : usum[W-1:0];
    o_sub_usat = udif[W] ? {W{1'b0}} : udif[W-1:0];
    // overflow when sign of inputs agree and result sign differs
    if (i_a[W-1] == i_b[W-1] && usum[W-1] != i_a[W-1])
      o_add_ssat = i_a[W-1] ? smin : smax;
    else
      o_add_ssat = usum[W-1:0];
    if (i_a[W-1] != i_b[W-1] && udif[W-1] != i_a[W-1])
      o_sub_ssat = i_a[W-1] ? smin : smax;
    else
      o_sub_ssat = udif[W-1:0];
  end

endmodule

// ### design/pmmcs_datapath.sv
// packed max/min, saturating add/sub, range clip and byte reverse datapath
// What this block does
// - byte reverse swaps the four bytes inside every doubleword of 16 bytes.
// - signed word max gives per lane the larger signed 16-bit element.
// - signed word min gives per lane the smaller signed 16-bit element.
// - unsigned byte max gives per lane the larger unsigned 8-bit element.
// - unsigned byte min gives per lane the smaller unsigned 8-bit element.
// - max and min also work on 128-bit operands with twice the lanes.
// - 128-bit max and min also cover signed byte, unsigned word and both dword kinds.
// - clip replaces elements below low by low and above high by high.
// - saturating add and subtract exist only for byte and word elements.
// - plain word add wraps modulo 2^16 so adding 0x8000 flips to unsigned order.
// - unsigned saturating add clamps at all ones and subtract at zero.
// - signed saturating add and subtract clamp to the signed element limits.
`timescale 1ns/1ps
module pmmcs_datapath #(
  parameter int unsigned DW = pmmcs_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // issued operation
  input  wire logic                  i_valid,
  input  wire pmmcs_pkg::pmmcs_op_e  i_op,
  input  wire pmmcs_pkg::pmmcs_size_e i_size,
  input  wire logic                  i_signed,
  input  wire logic                  i_wide,
  input  wire logic [DW-1:0]         i_src_a,
  input  wire logic [DW-1:0]         i_src_b,
  input  wire logic [DW-1:0]         i_src_c,
  // result
  output logic                       o_valid,
  output logic [DW-1:0]              o_result,
  output logic                       o_illegal
);

  // lane counts per element size
  localparam int unsigned NB = DW / 8;
  localparam int unsigned NW = DW / 16;
  localparam int unsigned ND = DW / 32;

  // per-size lane results
  logic [DW-1:0] b_max, b_min, b_addw, b_subw, b_adds, b_subs, b_addu, b_subu;
  logic [DW-1:0] w_max, w_min, w_addw, w_subw, w_adds, w_subs, w_addu, w_subu;
  logic [DW-1:0] d_max, d_min, d_addw, d_subw;
  // clip stage: min against high (src_b), then max against low (src_c)
  logic [DW-1:0] b_clip_hi, b_clip, w_clip_hi, w_clip, d_clip_hi, d_clip;
  logic [DW-1:0] rev;

  // legality terms, kept apart so each refusal reads on its own
  logic          op_is_sat;
  logic          op_is_cmp;
  logic          narrow_cmp_ok;
  logic          narrow_dword_clip;
  logic          size_bad;

  // stage inputs and their registered copies
  logic          next_valid;
  logic [DW-1:0] next_result;
  logic          next_illegal;
  logic          valid;
  logic [DW-1:0] result;
  logic          illegal;
  logic [DW-1:0] sel;
  logic [DW-1:0] lane_mask;

  // one genvar serves all three lane loops
  genvar g;

  // byte lanes, each instance isolated so no carry crosses
  // clip spends two extra lanes per element so both bounds settle in one cycle
  generate
    for (g = 0; g < NB; g++)
    begin : g_byte
      pmmcs_lane_cmp #(.W(8)) u_lane (
        .i_a        (i_src_a[g*8 +: 8]),
        .i_b        (i_src_b[g*8 +: 8]),
        .i_signed   (i_signed),
        .o_max      (b_max[g*8 +: 8]),
        .o_min      (b_min[g*8 +: 8]),
        .o_add_wrap (b_addw[g*8 +: 8]),
        .o_sub_wrap (b_subw[g*8 +: 8]),
        .o_add_ssat (b_adds[g*8 +: 8]),
        .o_sub_ssat (b_subs[g*8 +: 8]),
        .o_add_usat (b_addu[g*8 +: 8]),
        .o_sub_usat (b_subu[g*8 +: 8])
      );
      pmmcs_lane_cmp #(.W(8)) u_clip_hi (
        .i_a        (i_src_a[g*8 +: 8]),
        .i_b        (i_src_b[g*8 +: 8]),
        .i_signed   (i_signed),
        .o_max      (),
        .o_min      (b_clip_hi[g*8 +: 8]),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
      pmmcs_lane_cmp #(.W(8)) u_clip_lo (
        .i_a        (b_clip_hi[g*8 +: 8]),
        .i_b        (i_src_c[g*8 +: 8]),
        .i_signed   (i_signed),
        .o_max      (b_clip[g*8 +: 8]),
        .o_min      (),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
    end
  endgenerate

  // word lanes
  // the first clip lane repeats the plain min; kept apart to stay per-op readable
  generate
    for (g = 0; g < NW; g++)
    begin : g_word
      pmmcs_lane_cmp #(.W(16)) u_lane (
        .i_a        (i_src_a[g*16 +: 16]),
        .i_b        (i_src_b[g*16 +: 16]),
        .i_signed   (i_signed),
        .o_max      (w_max[g*16 +: 16]),
        .o_min      (w_min[g*16 +: 16]),
        .o_add_wrap (w_addw[g*16 +: 16]),
        .o_sub_wrap (w_subw[g*16 +: 16]),
        .o_add_ssat (w_adds[g*16 +: 16]),
        .o_sub_ssat (w_subs[g*16 +: 16]),
        .o_add_usat (w_addu[g*16 +: 16]),
        .o_sub_usat (w_subu[g*16 +: 16])
      );
      pmmcs_lane_cmp #(.W(16)) u_clip_hi (
        .i_a        (i_src_a[g*16 +: 16]),
        .i_b        (i_src_b[g*16 +: 16]),
        .i_signed   (i_signed),
        .o_max      (),
        .o_min      (w_clip_hi[g*16 +: 16]),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
      pmmcs_lane_cmp #(.W(16)) u_clip_lo (
        .i_a        (w_clip_hi[g*16 +: 16]),
        .i_b        (i_src_c[g*16 +: 16]),
        .i_signed   (i_signed),
        .o_max      (w_clip[g*16 +: 16]),
        .o_min      (),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
    end
  endgenerate

  // dword lanes; saturating outputs are left open since they do not exist
  // low above high leaves the low bound, since the max against it comes last
  generate
    for (g = 0; g < ND; g++)
    begin : g_dword
      pmmcs_lane_cmp #(.W(32)) u_lane (
        .i_a        (i_src_a[g*32 +: 32]),
        .i_b        (i_src_b[g*32 +: 32]),
        .i_signed   (i_signed),
        .o_max      (d_max[g*32 +: 32]),
        .o_min      (d_min[g*32 +: 32]),
        .o_add_wrap (d_addw[g*32 +: 32]),
        .o_sub_wrap (d_subw[g*32 +: 32]),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
      pmmcs_lane_cmp #(.W(32)) u_clip_hi (
        .i_a        (i_src_a[g*32 +: 32]),
        .i_b        (i_src_b[g*32 +: 32]),
        .i_signed   (i_signed),
        .o_max      (),
        .o_min      (d_clip_hi[g*32 +: 32]),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
      pmmcs_lane_cmp #(.W(32)) u_clip_lo (
        .i_a        (d_clip_hi[g*32 +: 32]),
        .i_b        (i_src_c[g*32 +: 32]),
        .i_signed   (i_signed),
        .o_max      (d_clip[g*32 +: 32]),
        .o_min      (),
        .o_add_wrap (),
        .o_sub_wrap (),
        .o_add_ssat (),
        .o_sub_ssat (),
        .o_add_usat (),
        .o_sub_usat ()
      );
      // byte reverse inside each doubleword, pattern 3,2,1,0 per group
      assign rev[g*32 +: 32] = {i_src_a[g*32 +: 8], i_src_a[g*32+8 +: 8],
                                i_src_a[g*32+16 +: 8], i_src_a[g*32+24 +: 8]};
    end
  endgenerate

  // result select and legality check
  always_comb
  begin
    // legality terms first; the select below leans on them
    op_is_sat         = i_op inside {pmmcs_pkg::PMMCS_OP_ADD_SSAT, pmmcs_pkg::PMMCS_OP_SUB_SSAT,
                                     pmmcs_pkg::PMMCS_OP_ADD_USAT, pmmcs_pkg::PMMCS_OP_SUB_USAT};
    op_is_cmp         = i_op inside {pmmcs_pkg::PMMCS_OP_MAX, pmmcs_pkg::PMMCS_OP_MIN};
    narrow_cmp_ok     = (i_size == pmmcs_pkg::PMMCS_SZ_WORD && i_signed) ||
                        (i_size == pmmcs_pkg::PMMCS_SZ_BYTE && !i_signed);
    narrow_dword_clip = !i_wide && i_size == pmmcs_pkg::PMMCS_SZ_DWORD &&
                        i_op == pmmcs_pkg::PMMCS_OP_CLIP;
    size_bad          = !(i_size inside {pmmcs_pkg::PMMCS_SZ_BYTE, pmmcs_pkg::PMMCS_SZ_WORD,
                                         pmmcs_pkg::PMMCS_SZ_DWORD});
    next_illegal = 1'b0;
    sel = '0;
    unique case (i_op)
      pmmcs_pkg::PMMCS_OP_PASS:     sel = i_src_a;
      pmmcs_pkg::PMMCS_OP_BYTE_REV: sel = rev;
      pmmcs_pkg::PMMCS_OP_MAX:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_max :
              (i_size == pmmcs_pkg::PMMCS_SZ_WORD) ? w_max : d_max;
      pmmcs_pkg::PMMCS_OP_MIN:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_min :
              (i_size == pmmcs_pkg::PMMCS_SZ_WORD) ? w_min : d_min;
      pmmcs_pkg::PMMCS_OP_ADD_WRAP:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_addw :
              (i_size == pmmcs_pkg::PMMCS_SZ_WORD) ? w_addw : d_addw;
      pmmcs_pkg::PMMCS_OP_SUB_WRAP:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_subw :
              (i_size == pmmcs_pkg::PMMCS_SZ_WORD) ? w_subw : d_subw;
      pmmcs_pkg::PMMCS_OP_ADD_SSAT:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_adds : w_adds;
      pmmcs_pkg::PMMCS_OP_SUB_SSAT:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_subs : w_subs;
      pmmcs_pkg::PMMCS_OP_ADD_USAT:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_addu : w_addu;
      pmmcs_pkg::PMMCS_OP_SUB_USAT:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_subu : w_subu;
      pmmcs_pkg::PMMCS_OP_CLIP:
        sel = (i_size == pmmcs_pkg::PMMCS_SZ_BYTE) ? b_clip :
              (i_size == pmmcs_pkg::PMMCS_SZ_WORD) ? w_clip : d_clip;
      default: next_illegal = 1'b1;
    endcase
    // no saturating dword form exists; flag it and return zero
    if (op_is_sat && i_size == pmmcs_pkg::PMMCS_SZ_DWORD)
    begin
      next_illegal = 1'b1;
      sel = '0;
    end
    // narrow form only offers signed word and unsigned byte max/min
    if (!i_wide && op_is_cmp && !narrow_cmp_ok)
    begin
      next_illegal = 1'b1;
      sel = '0;
    end
    // narrow dword clip has no 64-bit form behind it
    if (narrow_dword_clip)
      next_illegal = 1'b1;
    // the spare size code is refused for every op but pass and byte reverse, rather than read as a dword
    if (size_bad && i_op != pmmcs_pkg::PMMCS_OP_PASS && i_op != pmmcs_pkg::PMMCS_OP_BYTE_REV)
      next_illegal = 1'b1;
    // narrow form keeps the low 64 bits and zeroes the rest
    lane_mask = i_wide ? {DW{1'b1}} : {{(DW-pmmcs_pkg::NARROW_W){1'b0}},
                                         {pmmcs_pkg::NARROW_W{1'b1}}};
    next_result = (i_valid && !next_illegal) ? (sel & lane_mask) : '0;
    next_valid  = i_valid;
    next_illegal = i_valid & next_illegal;
  end

  // one pipeline stage of registers; a bubble is simply valid low
  // with its result held at zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      valid   <= 1'b0;
      result  <= '0;
      illegal <= 1'b0;
    end
    else
    begin
      valid   <= next_valid;
      result  <= next_result;
      illegal <= next_illegal;
    end
  end

  // outputs come straight from the stage flops
  assign o_valid   = valid;
  assign o_result  = result;
  assign o_illegal = illegal;

endmodule

// ### verification/pmmcs_chk.sv
// concurrent checks on the packed datapath ports
`timescale 1ns/1ps
module pmmcs_chk #(
  parameter int unsigned DW = 128
) (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  // issued operation
  input wire logic                   i_valid,
  input wire pmmcs_pkg::pmmcs_op_e   i_op,
  input wire pmmcs_pkg::pmmcs_size_e i_size,
  input wire logic                   i_signed,
  input wire logic                   i_wide,
  input wire logic [DW-1:0]          i_src_a,
  input wire logic [DW-1:0]          i_src_b,
  input wire logic [DW-1:0]          i_src_c,
  // result
  input wire logic                   o_valid,
  input wire logic [DW-1:0]          o_result,
  input wire logic                   o_illegal
);
  logic [DW-1:0] rev_a;
  logic [DW-1:0] umin_b;
  logic [DW-1:0] smax_w;
  logic [DW-1:0] usat_w;
  logic [16:0]   sum;
  logic [7:0]    ba;
  logic [7:0]    bb;

  // reference lanes built here, so a slip in shared lane code is not mirrored
  always_comb
  begin
    sum = '0;
    for (int g = 0; g < 16; g++)
    begin
      ba = i_src_a[8*g +: 8];
      bb = i_src_b[8*g +: 8];
      rev_a[8*g +: 8] = i_src_a[8*((g & ~3) + 3 - (g & 3)) +: 8];
      umin_b[8*g +: 8] = (ba < bb) ? ba : bb;
    end
    for (int g = 0; g < 8; g++)
    begin
      sum = {1'b0, i_src_a[16*g +: 16]} + {1'b0, i_src_b[16*g +: 16]};
      usat_w[16*g +: 16] = sum[16] ? 16'hFFFF : sum[15:0];
      smax_w[16*g +: 16] = ($signed(i_src_a[16*g +: 16]) > $signed(i_src_b[16*g +: 16]))
                           ? i_src_a[16*g +: 16] : i_src_b[16*g +: 16];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_byte_reverse: assert property (
    i_valid && i_op == pmmcs_pkg::PMMCS_OP_BYTE_REV && i_wide |=> o_result == $past(rev_a))
    else $error("byte reverse result wrong");
  a_sword_max: assert property (
    i_valid && i_op == pmmcs_pkg::PMMCS_OP_MAX && i_size == pmmcs_pkg::PMMCS_SZ_WORD
    && i_signed && i_wide |=> o_result == $past(smax_w))
    else $error("signed word max wrong");
  a_ubyte_min: assert property (
    i_valid && i_op == pmmcs_pkg::PMMCS_OP_MIN && i_size == pmmcs_pkg::PMMCS_SZ_BYTE
    && !i_signed && i_wide |=> o_result == $past(umin_b))
    else $error("unsigned byte min wrong");
  a_narrow_upper_zero: assert property (
    i_valid && !i_wide |=> o_valid && o_result[DW-1:64] == '0)
    else $error("narrow form upper half not zero");
  a_sat_dword_refused: assert property (
    i_valid && i_size == pmmcs_pkg::PMMCS_SZ_DWORD && i_op inside {pmmcs_pkg::PMMCS_OP_ADD_SSAT,
    pmmcs_pkg::PMMCS_OP_SUB_SSAT, pmmcs_pkg::PMMCS_OP_ADD_USAT, pmmcs_pkg::PMMCS_OP_SUB_USAT}
    |=> o_illegal && o_result == '0)
    else $error("dword saturating op not refused");
  a_wide_kinds_legal: assert property (
    i_valid && i_wide && i_op inside {pmmcs_pkg::PMMCS_OP_MAX, pmmcs_pkg::PMMCS_OP_MIN}
    |=> o_valid && !o_illegal)
    else $error("wide max or min refused");
  a_wrap_sign_offset: assert property (
    i_valid && i_op == pmmcs_pkg::PMMCS_OP_ADD_WRAP && i_size == pmmcs_pkg::PMMCS_SZ_WORD
    && i_wide && i_src_b == {8{16'h8000}} |=> o_result == ($past(i_src_a) ^ {8{16'h8000}}))
    else $error("wrapping offset add wrong");
  a_usat_add_clamp: assert property (
    i_valid && i_op == pmmcs_pkg::PMMCS_OP_ADD_USAT && i_size == pmmcs_pkg::PMMCS_SZ_WORD
    && i_wide |=> o_result == $past(usat_w))
    else $error("unsigned saturating add wrong");

  c_clip: cover property (i_valid && i_op == pmmcs_pkg::PMMCS_OP_CLIP);
  c_rev: cover property (i_valid && i_op == pmmcs_pkg::PMMCS_OP_BYTE_REV);
  c_illegal: cover property (o_illegal);
endmodule

bind pmmcs_datapath pmmcs_chk #(.DW(DW)) chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_valid(i_valid), .i_op(i_op), .i_size(i_size), .i_signed(i_signed), .i_wide(i_wide),
  .i_src_a(i_src_a), .i_src_b(i_src_b), .i_src_c(i_src_c), .o_valid(o_valid),
  .o_result(o_result), .o_illegal(o_illegal));

// ### verification/pmmcs_issuer.sv
// issue pipeline model feeding the packed datapath
`timescale 1ns/1ps
module pmmcs_issuer (
  // clock and returned result
  input  wire logic              i_clk,
  input  wire logic [127:0]      i_result,
  // issued operation
  output logic                   o_valid,
  output pmmcs_pkg::pmmcs_op_e   o_op,
  output pmmcs_pkg::pmmcs_size_e o_size,
  output logic                   o_signed,
  output logic                   o_wide,
  output logic [127:0]           o_src_a,
  output logic [127:0]           o_src_b,
  output logic [127:0]           o_src_c
);
  // called at a falling edge; returns one falling edge later with the result settled
  task automatic issue(input pmmcs_pkg::pmmcs_op_e op, input pmmcs_pkg::pmmcs_size_e sz,
                       input logic sg, wd, input logic [127:0] a, b, c);
    o_valid = 1'b1;
    o_op = op;
    o_size = sz;
    o_signed = sg;
    o_wide = wd;
    o_src_a = a;
    o_src_b = b;
    o_src_c = c;
    @(negedge i_clk);
  endtask

  // idle operands flip so a stale value can never pass for a live one;
  // one quiet cycle, so the next issue never rewrites valid in the same step
  task automatic idle();
    o_valid = 1'b0;
    o_src_a = ~o_src_a;
    o_src_b = ~o_src_b;
    o_src_c = ~o_src_c;
    @(negedge i_clk);
  endtask

  // narrow signed range needs the unsigned detour, else the middle step adds
  task automatic clip_seq(input logic [127:0] a, input logic [15:0] hi, lo);
    logic [15:0] hu;
    logic [15:0] lu;
    hu = hi ^ 16'h8000;
    lu = lo ^ 16'h8000;
    issue(pmmcs_pkg::PMMCS_OP_ADD_WRAP, pmmcs_pkg::PMMCS_SZ_WORD, 1'b1, 1'b1, a,
          {8{16'h8000}}, a);
    issue(pmmcs_pkg::PMMCS_OP_ADD_USAT, pmmcs_pkg::PMMCS_SZ_WORD, 1'b0, 1'b1, i_result,
          {8{16'hFFFF - hu}}, a);
    issue(pmmcs_pkg::PMMCS_OP_SUB_USAT, pmmcs_pkg::PMMCS_SZ_WORD, 1'b0, 1'b1, i_result,
          {8{16'hFFFF - hu + lu}}, a);
    issue(pmmcs_pkg::PMMCS_OP_ADD_WRAP, pmmcs_pkg::PMMCS_SZ_WORD, 1'b1, 1'b1, i_result,
          {8{lo}}, a);
  endtask

  // quiet start before reset releases
  initial
  begin
    o_op = pmmcs_pkg::PMMCS_OP_PASS;
    o_size = pmmcs_pkg::PMMCS_SZ_BYTE;
    o_signed = 1'b0;
    o_wide = 1'b0;
    o_src_a = '0;
    o_src_b = '0;
    o_src_c = '0;
    idle();
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the packed datapath
`timescale 1ns/1ps
module tb;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   v;
  pmmcs_pkg::pmmcs_op_e   op;
  pmmcs_pkg::pmmcs_size_e sz;
  logic                   sg;
  logic                   wd;
  logic [127:0]           a;
  logic [127:0]           b;
  logic [127:0]           c;
  logic                   ov;
  logic [127:0]           res;
  logic                   ill;
  int                     bad_count = 0;
  int                     comparisons = 0;
  localparam logic [127:0] CA = 128'h8000_7FFF_0010_FFF0_0020_FFEF_0021_0000;
  localparam logic [127:0] CE = 128'hFFF0_0020_0010_FFF0_0020_FFF0_0020_0000;

  always #12.5 clk = ~clk;

  pmmcs_issuer iss (.i_clk(clk), .i_result(res), .o_valid(v), .o_op(op), .o_size(sz),
    .o_signed(sg), .o_wide(wd), .o_src_a(a), .o_src_b(b), .o_src_c(c));
  pmmcs_datapath uut (.i_clk(clk), .i_rst_n(rst_n), .i_valid(v), .i_op(op), .i_size(sz),
    .i_signed(sg), .i_wide(wd), .i_src_a(a), .i_src_b(b), .i_src_c(c), .o_valid(ov),
    .o_result(res), .o_illegal(ill));

  task automatic check(input logic [129:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic t_rev_narrow();
    iss.issue(pmmcs_pkg::PMMCS_OP_BYTE_REV, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b1,
      128'h00112233_44556677_8899AABB_CCDDEEFF, '1, '0);
    check({ov, ill, res}, {2'b10, 128'h33221100_77665544_BBAA9988_FFEEDDCC});
    iss.issue(pmmcs_pkg::PMMCS_OP_MAX, pmmcs_pkg::PMMCS_SZ_WORD, 1'b1, 1'b0,
      {64'hFFFF, 64'h8000_7FFF_FFFF_0001}, {64'h1234, 64'h0000_8000_0001_FFFF}, '0);
    check({ov, ill, res}, {2'b10, 64'h0, 64'h0000_7FFF_0001_0001});
    iss.issue(pmmcs_pkg::PMMCS_OP_MIN, pmmcs_pkg::PMMCS_SZ_WORD, 1'b1, 1'b0,
      {64'hFFFF, 64'h8000_7FFF_FFFF_0001}, {64'h1234, 64'h0000_8000_0001_FFFF}, '0);
    check({ov, ill, res}, {2'b10, 64'h0, 64'h8000_8000_FFFF_FFFF});
    iss.issue(pmmcs_pkg::PMMCS_OP_MAX, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b0,
      {64'h1, 64'h00FF_807F_0102_FE01}, {64'h2, 64'hFF00_7F80_0201_01FE}, '0);
    check({ov, ill, res}, {2'b10, 64'h0, 64'hFFFF_8080_0202_FEFE});
    iss.issue(pmmcs_pkg::PMMCS_OP_MIN, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b0,
      {64'h1, 64'h00FF_807F_0102_FE01}, {64'h2, 64'hFF00_7F80_0201_01FE}, '0);
    check({ov, ill, res}, {2'b10, 64'h0, 64'h0000_7F7F_0101_0101});
    iss.idle();
    $display("test rev_narrow done");
  endtask

  // every size and signedness, back to back, sign bit decides the winner
  task automatic t_kinds();
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 4; k++)
      begin
        iss.issue(k[1] ? pmmcs_pkg::PMMCS_OP_MIN : pmmcs_pkg::PMMCS_OP_MAX,
          pmmcs_pkg::pmmcs_size_e'(s), k[0], 1'b1, {16{8'h80}}, {16{8'h01}}, '0);
        check({ov, ill, res}, {2'b10, (k[1] == k[0]) ? {16{8'h80}} : {16{8'h01}}});
      end
    iss.idle();
    $display("test kinds done");
  endtask

  task automatic t_arith();
    logic [63:0] e [6];
    e = '{64'h8000_8001_0000_0001, 64'h7FFE_7FFF_FFFE_FFFF, 64'h7FFF_8001_0000_0001,
          64'h7FFE_8000_FFFE_FFFF, 64'h8000_8001_FFFF_0001, 64'h7FFE_7FFF_FFFE_0000};
    for (int i = 0; i < 6; i++)
    begin
      iss.issue(pmmcs_pkg::pmmcs_op_e'(pmmcs_pkg::PMMCS_OP_ADD_WRAP + i),
        pmmcs_pkg::PMMCS_SZ_WORD, 1'b0, 1'b1, {2{64'h7FFF_8000_FFFF_0000}}, {8{16'h0001}}, '0);
      check({ov, ill, res}, {2'b10, {2{e[i]}}});
    end
    for (int i = 0; i < 4; i++)
    begin
      iss.issue(pmmcs_pkg::pmmcs_op_e'(pmmcs_pkg::PMMCS_OP_ADD_SSAT + i),
        pmmcs_pkg::PMMCS_SZ_DWORD, 1'b0, 1'b1, '1, '1, '0);
      check({ov, ill, res}, {2'b11, 128'h0});
    end
    iss.issue(pmmcs_pkg::PMMCS_OP_MAX, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b1, 1'b0, '1, '0, '0);
    check({ov, ill, res}, {2'b11, 128'h0});
    iss.idle();
    $display("test arith done");
  endtask

  // direct clip, then the issuer's saturating detour over a narrow range
  task automatic t_clip();
    iss.issue(pmmcs_pkg::PMMCS_OP_CLIP, pmmcs_pkg::PMMCS_SZ_WORD, 1'b1, 1'b1, CA,
      {8{16'h0020}}, {8{16'hFFF0}});
    check({ov, ill, res}, {2'b10, CE});
    iss.clip_seq(CA, 16'h0020, 16'hFFF0);
    check({ov, ill, res}, {2'b10, CE});
    iss.idle();
    $display("test clip done");
  endtask

  // pass, byte saturation, narrow byte clip, dword clip, refusal and a bubble
  task automatic t_misc();
    iss.issue(pmmcs_pkg::PMMCS_OP_PASS, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b0, CA, '0, '0);
    check({ov, ill, res}, {2'b10, 64'h0, CA[63:0]});
    iss.issue(pmmcs_pkg::PMMCS_OP_ADD_SSAT, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b1, 1'b1,
      {8{16'h7F80}}, {16{8'h01}}, '0);
    check({ov, ill, res}, {2'b10, {8{16'h7F81}}});
    iss.issue(pmmcs_pkg::PMMCS_OP_SUB_USAT, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b1,
      {8{16'h0080}}, {16{8'h01}}, '0);
    check({ov, ill, res}, {2'b10, {8{16'h007F}}});
    iss.issue(pmmcs_pkg::PMMCS_OP_CLIP, pmmcs_pkg::PMMCS_SZ_BYTE, 1'b0, 1'b0,
      {64'hFFFF, 64'h0010_20FF_0580_7F81}, {16{8'h80}}, {16{8'h10}});
    check({ov, ill, res}, {2'b10, 64'h0, 64'h1010_2080_1080_7F80});
    iss.issue(pmmcs_pkg::PMMCS_OP_CLIP, pmmcs_pkg::PMMCS_SZ_DWORD, 1'b1, 1'b1,
      128'h8000_0000_7FFF_FFFF_0000_1000_FFFF_FFFF, {4{32'h0001_0000}},
      {4{32'hFFFF_0000}});
    check({ov, ill, res}, {2'b10, 128'hFFFF_0000_0001_0000_0000_1000_FFFF_FFFF});
    iss.issue(pmmcs_pkg::PMMCS_OP_CLIP, pmmcs_pkg::PMMCS_SZ_DWORD, 1'b1, 1'b0, '1, '0, '0);
    check({ov, ill, res}, {2'b11, 128'h0});
    iss.idle();
    check({ov, ill, res}, {2'b00, 128'h0});
    $display("test misc done");
  endtask

  task automatic end_sim();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // whole run is under a hundred cycles; the limit leaves wide margin
  initial
  begin
    #(25 * 3000);
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_rev_narrow();
    t_kinds();
    t_arith();
    t_clip();
    t_misc();
    end_sim();
  end
endmodule
